/* File: hbc_defines.svh */
// timing constants for the motor bridge host controller
// assumes a 25 MHz system clock; the ns figures are plain defaults
`ifndef HBC_DEFINES_SVH
`define HBC_DEFINES_SVH
`define HBC_CLK_PERIOD_NS 40
`define HBC_WAKE_HOLD_NS 100000
`define HBC_AUTOSLEEP_DELAY_NS 100000
`define HBC_SUPPLY_SETTLE_NS 40000
`define HBC_TIMER_W 12
`define HBC_DUTY_W 8
`define HBC_PWM_TOP 8'hFE
`endif

/* File: hbc_pkg.sv */
// types and cycle arithmetic for the motor bridge host controller
// assumes hbc_defines.svh is on the include path
`include "hbc_defines.svh"
package hbc_pkg;
  typedef enum logic [5:0] {
    HBC_ST_OFF = 6'h01,
    HBC_ST_SETTLE = 6'h02,
    HBC_ST_WAKE = 6'h04,
    HBC_ST_RUN = 6'h08,
    HBC_ST_DOZE = 6'h10,
    HBC_ST_ASLEEP = 6'h20
  } hbc_state_type;

  typedef enum logic [1:0] {
    HBC_MODE_PWM = 2'h0,
    HBC_MODE_PHEN = 2'h1,
    HBC_MODE_HALF = 2'h2
  } hbc_mode_type;

  // least time in ns to whole cycles, rounded up, at least one
  function automatic logic [`HBC_TIMER_W-1:0] hbc_cycles(input int ns);
    int c;
    c = (ns + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return `HBC_TIMER_W'(c);
  endfunction
endpackage

/* File: hbc_pwm.sv */
// free running pwm generator for the bridge control inputs
// assumes duty is a steady level from the same clock domain
`timescale 1ns/1ps
`include "hbc_defines.svh"
module hbc_pwm
  import hbc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`HBC_DUTY_W-1:0] duty_i,
  output logic pwm_o
);
  logic [`HBC_DUTY_W-1:0] cnt;

  // period of top+1 steps so that full scale duty gives 100%
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (cnt == `HBC_PWM_TOP) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + `HBC_DUTY_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pwm_o <= 1'b0;
    end else begin
      pwm_o <= (cnt < duty_i);
    end
  end
endmodule // hbc_pwm

/* File: hbc_host.sv */
// host controller driving a brushed-motor h-bridge through its pins
// assumes user inputs come from the same clock; mode pin is tri-level
`timescale 1ns/1ps
`include "hbc_defines.svh"
// Contract
// (R1) device wakes on non-sleep input states
// (R2) hold inputs high past wake time
// (R3) supply on first, then wake hold
// (R4) device ignores inputs below supply threshold
// (R5) device disables bridge on any fault
// (R6) device recovers from faults by itself
// (R7) floating mode pin selects half-bridge
// (R8) each half-bridge used low or high side
// (R9) mode high selects phase/enable, pwm on enable
// (R10) phase input sets drive direction
// (R11) enable low past delay enters sleep
// (R12) parallel mode ties both inputs together
// (R13) default mode pin tied low
// (R14) drive all inputs low in sleep
// (R15) overcurrent retries after delay, repeats
// (R16) half-bridge overcurrent hits one side only
// (R17) shared retry timer, second event restarts
// (R18) phase/enable autosleep brakes, then high-z
// (R19) disabled output turns off both switches
module hbc_host
  import hbc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic supply_sleep_i,
  input wire hbc_mode_type mode_sel_i,
  input wire logic parallel_i,
  input wire logic dir_i,
  input wire logic [1:0] half_en_i,
  input wire logic [`HBC_DUTY_W-1:0] duty_i,
  output logic control_input_a_o,
  output logic control_input_b_o,
  output logic mode_pin_o,
  output logic mode_pin_oe_o,
  output logic logic_supply_o,
  output logic awake_o,
  output logic asleep_o
);
  localparam logic [`HBC_TIMER_W-1:0] WAKE_CYC =
    hbc_cycles(`HBC_WAKE_HOLD_NS) + `HBC_TIMER_W'(1);
  localparam logic [`HBC_TIMER_W-1:0] DOZE_CYC =
    hbc_cycles(`HBC_AUTOSLEEP_DELAY_NS) + `HBC_TIMER_W'(1);
  localparam logic [`HBC_TIMER_W-1:0] SETTLE_CYC = hbc_cycles(`HBC_SUPPLY_SETTLE_NS);

  hbc_state_type st;
  hbc_state_type next_st;
  hbc_mode_type mode;
  logic par;
  logic [`HBC_TIMER_W-1:0] timer;
  logic pwm;
  logic next_a;
  logic next_b;
  logic next_oe;
  logic next_mode;

  hbc_pwm hbc_pwm_i (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .duty_i(duty_i),
    .pwm_o(pwm)
  );

  always_comb begin
    next_st = st;
    case (st)
      HBC_ST_OFF: begin
        if (run_i) begin
          next_st = HBC_ST_SETTLE;
        end
      end
      // (R4) wait for supply threshold
      HBC_ST_SETTLE: begin
        if (timer == '0) begin
          next_st = HBC_ST_WAKE;
        end
      end
      HBC_ST_WAKE: begin
        if (timer == '0) begin
          next_st = HBC_ST_RUN;
        end
      end
      HBC_ST_RUN: begin
        if (!run_i) begin
          next_st = supply_sleep_i ? HBC_ST_OFF : HBC_ST_DOZE;
        end
      end
      // (R11) device needs the full delay
      HBC_ST_DOZE: begin
        if (timer == '0) begin
          next_st = HBC_ST_ASLEEP;
        end
      end
      // (R1) any non-sleep input wakes it
      HBC_ST_ASLEEP: begin
        if (run_i) begin
          next_st = HBC_ST_WAKE;
        end
      end
      default: next_st = HBC_ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= HBC_ST_OFF;
    end else begin
      st <= next_st;
    end
  end

  // (R2) wake hold length per state entry
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      timer <= '0;
    end else if (next_st != st) begin
      case (next_st)
        HBC_ST_SETTLE: timer <= SETTLE_CYC;
        HBC_ST_WAKE: timer <= WAKE_CYC;
        HBC_ST_DOZE: timer <= DOZE_CYC;
        default: timer <= '0;
      endcase
    end else if (timer != '0) begin
      timer <= timer - `HBC_TIMER_W'(1);
    end
  end

  // mode changes only take effect through a wake, never mid-run
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mode <= HBC_MODE_PWM;
      par <= 1'b0;
    end else if (st == HBC_ST_OFF || st == HBC_ST_ASLEEP) begin
      mode <= mode_sel_i;
      par <= parallel_i;
    end
  end

  always_comb begin
    next_a = 1'b0;
    next_b = 1'b0;
    next_oe = 1'b1;
    next_mode = 1'b0;
    case (st)
      HBC_ST_WAKE: begin
        next_a = (mode == HBC_MODE_PHEN) ? dir_i : 1'b1;
        next_b = (mode == HBC_MODE_HALF) ? par : 1'b1;
      end
      HBC_ST_RUN: begin
        case (mode)
          // slow decay keeps one input high so no autosleep at low duty
          HBC_MODE_PWM: begin
            next_a = dir_i ? 1'b1 : ~pwm;
            next_b = dir_i ? ~pwm : 1'b1;
          end
          // (R10) phase on input a, enable carries pwm
          HBC_MODE_PHEN: begin
            next_a = dir_i;
            next_b = pwm;
          end
          // (R8) each side switched by its own input
          HBC_MODE_HALF: begin
            next_a = half_en_i[0] & pwm;
            // (R12) parallel copies side a
            next_b = par ? (half_en_i[0] & pwm) : (half_en_i[1] & pwm);
          end
          default: begin
            next_a = 1'b0;
            next_b = 1'b0;
          end
        endcase
      end
      // (R14) all inputs low asleep
      default: begin
        next_a = 1'b0;
        next_b = 1'b0;
      end
    endcase
    // (R7) float the pin for half-bridge in every state except off and asleep
    if (st != HBC_ST_OFF && st != HBC_ST_ASLEEP) begin
      next_oe = (mode != HBC_MODE_HALF);
      // (R9) drive high for phase/enable
      // (R13) pwm leaves pin low
      next_mode = (mode == HBC_MODE_PHEN);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      control_input_a_o <= 1'b0;
      control_input_b_o <= 1'b0;
      mode_pin_o <= 1'b0;
      mode_pin_oe_o <= 1'b1;
      logic_supply_o <= 1'b0;
      awake_o <= 1'b0;
      asleep_o <= 1'b0;
    end else begin
      control_input_a_o <= next_a;
      control_input_b_o <= next_b;
      mode_pin_o <= next_mode;
      mode_pin_oe_o <= next_oe;
      // (R3) supply rises before any wake activity
      logic_supply_o <= (next_st != HBC_ST_OFF);
      awake_o <= (next_st == HBC_ST_RUN);
      // follows st like the pins, so sleep never shows with inputs still high
      asleep_o <= (st == HBC_ST_OFF) || (st == HBC_ST_ASLEEP);
    end
  end

  // helper counters seen only by the checks
  logic [`HBC_TIMER_W-1:0] hold_cnt;
  logic [`HBC_TIMER_W-1:0] sup_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !(control_input_a_o || control_input_b_o)) begin
      hold_cnt <= '0;
    end else if (hold_cnt != '1) begin
      hold_cnt <= hold_cnt + `HBC_TIMER_W'(1);
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !logic_supply_o) begin
      sup_cnt <= '0;
    end else if (sup_cnt != '1) begin
      sup_cnt <= sup_cnt + `HBC_TIMER_W'(1);
    end
  end

  sequence s_wake_done;
    $rose(awake_o);
  endsequence
  sequence s_run_drop;
    (st == HBC_ST_RUN) && !run_i && !supply_sleep_i;
  endsequence

  a_wake_hold_long: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // (R2)
    s_wake_done |-> hold_cnt >= WAKE_CYC - `HBC_TIMER_W'(1))
    else $error("wake hold too short");
  a_supply_before_wake: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // (R3)
    (st == HBC_ST_WAKE) |-> logic_supply_o && (sup_cnt >= SETTLE_CYC))
    else $error("wake started before supply settled");
  a_parallel_tied: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // (R12)
    (st == HBC_ST_RUN && mode == HBC_MODE_HALF && par) ##1 (st == HBC_ST_RUN)
    |-> control_input_a_o == control_input_b_o)
    else $error("parallel inputs differ");
  a_mode_default_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // (R13)
    $past(mode == HBC_MODE_PWM) |-> mode_pin_oe_o && !mode_pin_o)
    else $error("mode pin not low for pwm");
  a_sleep_inputs_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // (R14)
    asleep_o |-> !control_input_a_o && !control_input_b_o && !mode_pin_o)
    else $error("inputs not low in sleep");
  a_doze_inputs_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // (R11)
    s_run_drop |=> ((st == HBC_ST_DOZE) [*8]) ##0 !control_input_b_o)
    else $error("doze cut short");
  a_half_floats: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // (R7)
    (st == HBC_ST_RUN && mode == HBC_MODE_HALF) |=> !mode_pin_oe_o)
    else $error("mode pin driven in half-bridge");
  a_phen_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // (R9)
    (st == HBC_ST_RUN && mode == HBC_MODE_PHEN) |=> mode_pin_oe_o && mode_pin_o)
    else $error("mode pin not high for phase/enable");
endmodule // hbc_host

/* File: hbc_device_model.sv */
// behavioural bridge device seen from its control pins
// assumes host pins change on the same clock; times given in cycles
`timescale 1ns/1ps
module hbc_device_model #(
  parameter int WAKE_CYC = 2500,
  parameter int SLEEP_CYC = 2500,
  parameter int RETRY_CYC = 4
) (
  input wire logic sys_clk_i,
  input wire logic supply_i,
  input wire logic in_a_i,
  input wire logic in_b_i,
  input wire logic mode_i,
  input wire logic mode_oe_i,
  input wire logic [1:0] fault_i,
  output logic awake_o,
  output logic [1:0] out_a_o,
  output logic [1:0] out_b_o
);
  // outputs are {high side, low side}
  int hold;
  int idle;
  logic phen;
  logic half;
  logic wake_in;
  int retry;
  logic [1:0] oc_hit;
  logic [1:0] blk;
  assign phen = mode_oe_i & mode_i;
  assign blk = fault_i | oc_hit;
  // one retry timer, restarted by any event
  always_ff @(posedge sys_clk_i) begin
    if (fault_i != 2'h0) begin
      retry <= RETRY_CYC;
      oc_hit <= oc_hit | fault_i;
    end else if (retry != 0) begin
      retry <= retry - 1;
    end else begin
      oc_hit <= 2'h0;
    end
  end
  assign half = !mode_oe_i;
  assign wake_in = phen ? in_b_i : (in_a_i | in_b_i);
  always_ff @(posedge sys_clk_i) begin
    if (!supply_i) begin
      awake_o <= 1'b0;
      hold <= 0;
      idle <= 0;
    end else if (!awake_o) begin
      hold <= wake_in ? hold + 1 : 0;
      idle <= 0;
      if (hold >= WAKE_CYC) begin
        awake_o <= 1'b1;
      end
    end else begin
      idle <= wake_in ? 0 : idle + 1;
      hold <= 0;
      if (idle >= SLEEP_CYC) begin
        awake_o <= 1'b0;
      end
    end
  end
  always_comb begin
    out_a_o = 2'h0;
    out_b_o = 2'h0;
    if (awake_o) begin
      if (phen) begin
        out_a_o = (in_b_i && in_a_i) ? 2'h2 : 2'h1;
        out_b_o = (in_b_i && !in_a_i) ? 2'h2 : 2'h1;
      end else if (half) begin
        out_a_o = in_a_i ? 2'h2 : 2'h1;
        out_b_o = in_b_i ? 2'h2 : 2'h1;
      end else if (in_a_i || in_b_i) begin
        out_a_o = (in_a_i && !in_b_i) ? 2'h2 : 2'h1;
        out_b_o = (in_b_i && !in_a_i) ? 2'h2 : 2'h1;
      end
      if (blk[0] || (!half && blk[1])) begin
        out_a_o = 2'h0;
      end
      if (blk[1] || (!half && blk[0])) begin
        out_b_o = 2'h0;
      end
    end
  end
endmodule // hbc_device_model

/* File: hbc_host_bench.sv */
// self-checking bench for the bridge host controller
// assumes hbc_pkg compiled first; outputs packed {hs,ls} per side
`timescale 1ns/1ps
module hbc_host_bench;
  import hbc_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic run_i = 1'b0;
  logic supply_sleep_i = 1'b0;
  logic parallel_i = 1'b0;
  logic dir_i = 1'b1;
  logic [1:0] fault = 2'h0;
  hbc_mode_type mode_sel_i = HBC_MODE_PWM;
  logic [1:0] half_en_i = 2'h1;
  logic [7:0] duty_i = 8'hFF;
  logic ctl_a, ctl_b, mp, mp_oe, sup, awake, asleep, dev_awake;
  logic [1:0] out_a, out_b;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  hbc_host hbc_host_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .run_i(run_i),
    .supply_sleep_i(supply_sleep_i), .mode_sel_i(mode_sel_i), .parallel_i(parallel_i),
    .dir_i(dir_i), .half_en_i(half_en_i), .duty_i(duty_i), .control_input_a_o(ctl_a),
    .control_input_b_o(ctl_b), .mode_pin_o(mp), .mode_pin_oe_o(mp_oe),
    .logic_supply_o(sup), .awake_o(awake), .asleep_o(asleep));
  hbc_device_model hbc_device_model_i (.sys_clk_i(sys_clk_i), .supply_i(sup),
    .in_a_i(ctl_a), .in_b_i(ctl_b), .mode_i(mp), .mode_oe_i(mp_oe), .fault_i(fault),
    .awake_o(dev_awake), .out_a_o(out_a), .out_b_o(out_b));
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait on awake (sel 0) or asleep (sel 1)
  task automatic wait_for(input bit sel, input int lim);
    int n;
    n = 0;
    while ((sel ? asleep : awake) !== 1'b1 && n < lim) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk({3'h0, n < lim}, 4'h1);
    repeat (3) @(negedge sys_clk_i);
  endtask
  task automatic results;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic t_pwm_wake;
    repeat (6) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk({ctl_a, ctl_b, sup, asleep}, 4'h1);
    run_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk({sup, asleep, ctl_a, ctl_b}, 4'h8);
    wait_for(1'b0, 4000);
    chk({dev_awake, mp_oe, mp, 1'b0}, 4'hC);
    chk({out_a, out_b}, 4'h9);
    dir_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk({out_a, out_b}, 4'h6);
  endtask
  task automatic t_supply_sleep;
    supply_sleep_i = 1'b1;
    run_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    supply_sleep_i = 1'b0;
    chk({sup, ctl_a, ctl_b, asleep}, 4'h1);
    chk({1'b0, dev_awake, out_a}, 4'h0);
  endtask
  task automatic t_half;
    mode_sel_i = HBC_MODE_HALF;
    dir_i = 1'b1;
    run_i = 1'b1;
    wait_for(1'b0, 4000);
    chk({mp_oe, dev_awake, ctl_b, ctl_a}, 4'h5);
    chk({out_a, out_b}, 4'h9);
    fault = 2'h2;
    repeat (2) @(negedge sys_clk_i);
    chk({out_a, out_b}, 4'h8);
    fault = 2'h0;
    repeat (2) @(negedge sys_clk_i);
    chk({out_a, out_b}, 4'h8);
    repeat (6) @(negedge sys_clk_i);
    chk({out_a, out_b}, 4'h9);
    fault = 2'h2;
    @(negedge sys_clk_i);
    fault = 2'h0;
    repeat (2) @(negedge sys_clk_i);
    fault = 2'h1;
    @(negedge sys_clk_i);
    fault = 2'h0;
    chk({out_a, out_b}, 4'h0);
    repeat (3) @(negedge sys_clk_i);
    chk({out_a, out_b}, 4'h0);
    repeat (4) @(negedge sys_clk_i);
    chk({out_a, out_b}, 4'h9);
    run_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk({ctl_a, ctl_b, awake, asleep}, 4'h0);
    wait_for(1'b1, 3000);
    chk({dev_awake, mp, ctl_a, ctl_b}, 4'h0);
  endtask
  task automatic t_phen;
    mode_sel_i = HBC_MODE_PHEN;
    run_i = 1'b1;
    wait_for(1'b0, 3000);
    chk({mp_oe, mp, ctl_b, dev_awake}, 4'hF);
    chk({out_a, out_b}, 4'h9);
    dir_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk({out_a, out_b}, 4'h6);
    run_i = 1'b0;
    repeat (10) @(negedge sys_clk_i);
    chk({out_a, out_b}, 4'h5);
    wait_for(1'b1, 3000);
    chk({dev_awake, 1'b0, out_a}, 4'h0);
  endtask
  task automatic t_parallel;
    mode_sel_i = HBC_MODE_HALF;
    parallel_i = 1'b1;
    run_i = 1'b1;
    wait_for(1'b0, 3000);
    chk({ctl_a, ctl_b, mp_oe, dev_awake}, 4'hD);
    chk({out_a, out_b}, 4'hA);
    half_en_i = 2'h2;
    repeat (3) @(negedge sys_clk_i);
    chk({2'h0, ctl_a, ctl_b}, 4'h0);
    supply_sleep_i = 1'b1;
    run_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    supply_sleep_i = 1'b0;
    chk({sup, ctl_a, ctl_b, asleep}, 4'h1);
  endtask
  // run ceiling well past the four wake/sleep cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    t_pwm_wake();
    t_supply_sleep();
    t_half();
    t_phen();
    t_parallel();
    results();
  end
endmodule // hbc_host_bench
